// *** core/emx_pkg.sv ***
package emx_pkg;

	// Address widths and windows
	localparam int ADDR_W = 14;
	localparam int OVL_W = 4;
	localparam int LOW_W = 13;
	localparam int IO_ADDR_W = 11;
	localparam int IO_REGION_LSB = 9;
	localparam int WAIT_FIELD_W = 3;
	localparam int WAIT_W = 4;
	localparam int NUM_IO_REGIONS = 4;
	localparam logic [ADDR_W-1:0] PM_WINDOW_LO = 14'h2000;
	localparam logic [ADDR_W-1:0] DM_WINDOW_HI = 14'h1FFF;
	localparam logic [ADDR_W-1:0] MMR_BASE = 14'h3FE0;

	// Overlay selector codes for the two external windows
	localparam logic [OVL_W-1:0] OVL_EXT1 = 4'h1;
	localparam logic [OVL_W-1:0] OVL_EXT2 = 4'h2;

	// Select vector bit positions
	localparam int NUM_SEL = 4;
	localparam int SEL_PM = 0;
	localparam int SEL_DM = 1;
	localparam int SEL_BM = 2;
	localparam int SEL_IO = 3;

	// Composite enables after reset: all set but byte space
	localparam logic [NUM_SEL-1:0] CSE_RESET = 4'hB;

	// Access controller states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_STROBE = 4'h2,
		ST_DONE = 4'h4,
		ST_GRANT = 4'h8
	} emx_state_t;

	// Space of an access
	typedef enum logic [1:0] {
		SP_PM = 2'h0,
		SP_DM = 2'h1,
		SP_BM = 2'h2,
		SP_IO = 2'h3
	} emx_space_t;

	// Access request from the core
	typedef struct packed {
		logic valid;
		emx_space_t space;
		logic write;
		logic fetch;
		logic [ADDR_W-1:0] addr;
	} emx_req_t;

	// Completion report to the core
	typedef struct packed {
		logic done;
		logic err;
		logic internal_hit;
		logic mmr_hit;
	} emx_rsp_t;

endpackage

// *** core/emx_sel_stage.sv ***
`timescale 1ns/100ps

// Registered memory select outputs plus composite select
module emx_sel_stage #(
	parameter int N = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Next-cycle selects, active high
	input wire logic [N-1:0] sel_next,
	input wire logic [N-1:0] enables,
	input wire logic release_next,
	// Pin side
	output logic [N-1:0] sel_n,
	output logic composite_n,
	output logic oe_n
);

	typedef struct packed {
		logic [N-1:0] sel_n;
		logic comp_n;
		logic oe_n;
	} emx_sel_st_t;

	emx_sel_st_t q, d;

	// Composite is built from the same next values, so it shares their timing
	always_comb begin
		d.sel_n = ~sel_next;
		d.comp_n = ~(|(sel_next & enables)); // R14 R15
		d.oe_n = release_next; // R16
		if (release_next) begin
			d.sel_n = '1; // R16
			d.comp_n = 1'b1; // R16
		end
	end

	// Select register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			q <= '{sel_n: '1, comp_n: 1'b1, oe_n: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign sel_n = q.sel_n;
	assign composite_n = q.comp_n;
	assign oe_n = q.oe_n;

endmodule

// *** core/emx_mem_ctrl.sv ***
// Operation
// R1 - Full mode: 24-bit PM, two 8K windows
// R2 - Overlay 0 or supported values select internal
// R3 - PM overlay 1/2: A13 low/high, 0x2000 window
// R4 - Host mode: overlay accesses use A0 only
// R5 - Host mode: no external instruction fetch
// R6 - 16-bit DM, top 32 words are registers
// R7 - DM overlay 1/2: A13 low/high, low window
// R8 - Internal DM single cycle; external uses wait
// R9 - I/O space 2048 words, upper bits undefined
// R10 - I/O reached only by dedicated I/O requests
// R11 - Four 3-bit I/O fields, up to 15
// R12 - I/O field chosen by address bits 10:9
// R13 - Host mode: outside logic extends I/O address
// R14 - Composite select shares the strobes' timing
// R15 - Composite select is OR of enabled selects
// R16 - Composite select released under bus grant
// R17 - Composite enables reset to one except byte
// R18 - Software writes zeros into reserved bits
// R19 - Fields without default are undefined after reset
// R20 - Memory mode strapped from flag pin in reset
// R21 - N wait states stretch strobe N cycles
// R22 - Unsupported overlay value selects nothing
`timescale 1ns/100ps

module emx_mem_ctrl #(
	parameter logic [15:0] PM_OVL_SUPPORTED = 16'h0001,
	parameter logic [15:0] DM_OVL_SUPPORTED = 16'h0001
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Mode strap, shared with the flag pin
	input wire logic flag_pin_two,
	output logic host_mode,
	// Overlay and wait configuration
	input wire logic [emx_pkg::OVL_W-1:0] program_overlay_select,
	input wire logic [emx_pkg::OVL_W-1:0] data_overlay_select,
	input wire logic [emx_pkg::WAIT_FIELD_W-1:0] data_ext_wait_count,
	input wire logic [emx_pkg::WAIT_W-1:0] byte_wait_count,
	input wire logic [emx_pkg::NUM_IO_REGIONS*emx_pkg::WAIT_FIELD_W-1:0] io_region_wait_counts,
	input wire logic wait_mode,
	// Composite select enable register
	input wire logic cse_wr,
	input wire logic [emx_pkg::NUM_SEL-1:0] cse_wdata,
	output logic [emx_pkg::NUM_SEL-1:0] composite_select_enables,
	// Core access port
	input wire emx_pkg::emx_req_t req,
	output logic req_ready,
	output emx_pkg::emx_rsp_t rsp,
	// Bus arbitration
	input wire logic bus_request,
	output logic bus_grant,
	// External memory pins
	output logic [emx_pkg::ADDR_W-1:0] ext_addr,
	output logic ext_rd_n,
	output logic ext_wr_n,
	output logic program_space_select_n,
	output logic data_space_select_n,
	output logic byte_space_select_n,
	output logic io_space_select_n,
	output logic composite_chip_select_n,
	output logic select_oe_n
);

	// Whole controller state
	typedef struct packed {
		emx_pkg::emx_state_t state;
		logic [emx_pkg::WAIT_W-1:0] cnt;
		logic [emx_pkg::ADDR_W-1:0] addr;
		logic rd;
		logic wr;
		logic [emx_pkg::NUM_SEL-1:0] sel;
		emx_pkg::emx_rsp_t rsp;
		logic host;
		logic [emx_pkg::NUM_SEL-1:0] cse;
	} emx_ctrl_st_t;

	localparam emx_ctrl_st_t CTRL_RESET = '{
		state: emx_pkg::ST_IDLE,
		cnt: '0,
		addr: '0,
		rd: 1'b0,
		wr: 1'b0,
		sel: '0,
		rsp: '0,
		host: 1'b0,
		cse: emx_pkg::CSE_RESET
	};

	emx_ctrl_st_t q, d;

	// Decode results for the request at the port
	logic dec_ext;
	logic dec_int;
	logic dec_err;
	logic dec_mmr;
	logic [emx_pkg::ADDR_W-1:0] dec_addr;
	logic [emx_pkg::NUM_SEL-1:0] dec_sel;
	logic [emx_pkg::WAIT_W-1:0] dec_wait;
	logic [1:0] io_region;
	logic [emx_pkg::WAIT_FIELD_W-1:0] io_field;
	logic release_next;

	// Field plus mode bit to a wait count of 0..15
	function automatic logic [emx_pkg::WAIT_W-1:0] wait_of(
		input logic [emx_pkg::WAIT_FIELD_W-1:0] field,
		input logic mode
	);
		logic [emx_pkg::WAIT_W-1:0] n;
		if (mode) begin
			n = {field, 1'b1};
		end else begin
			n = {1'b0, field};
		end
		return n;
	endfunction

	// Map an overlay window hit onto internal, external or nothing
	function automatic logic [2:0] ovl_map(
		input logic [emx_pkg::OVL_W-1:0] ovl,
		input logic [15:0] supported
	);
		logic [2:0] r;
		r = 3'h0;
		if (ovl == emx_pkg::OVL_EXT1 || ovl == emx_pkg::OVL_EXT2) begin
			r = 3'h1;
		end else if (supported[ovl]) begin
			r = 3'h2;
		end else begin
			r = 3'h4;
		end
		return r;
	endfunction

	// I/O wait field picked from address bits 10:9
	always_comb begin
		io_region = req.addr[emx_pkg::IO_REGION_LSB+1:emx_pkg::IO_REGION_LSB]; // R12
		io_field = io_region_wait_counts[io_region*emx_pkg::WAIT_FIELD_W +: emx_pkg::WAIT_FIELD_W]; // R11
	end

	// Address and space decode of the pending request
	always_comb begin
		logic [2:0] m;
		m = 3'h0;
		dec_ext = 1'b0;
		dec_int = 1'b0;
		dec_err = 1'b0;
		dec_mmr = 1'b0;
		dec_addr = req.addr;
		dec_sel = '0;
		dec_wait = '0;
		unique case (req.space)
			emx_pkg::SP_PM: begin
				if (req.addr >= emx_pkg::PM_WINDOW_LO) begin
					m = ovl_map(program_overlay_select, PM_OVL_SUPPORTED); // R2 R22
					// A13 tells the two external windows apart
					dec_addr = {program_overlay_select == emx_pkg::OVL_EXT2,
						req.addr[emx_pkg::LOW_W-1:0]}; // R1 R3
				end else begin
					m = 3'h2;
				end
				dec_sel[emx_pkg::SEL_PM] = 1'b1;
				dec_wait = '0;
			end
			emx_pkg::SP_DM: begin
				if (req.addr <= emx_pkg::DM_WINDOW_HI) begin
					m = ovl_map(data_overlay_select, DM_OVL_SUPPORTED); // R22
					dec_addr = {data_overlay_select == emx_pkg::OVL_EXT2,
						req.addr[emx_pkg::LOW_W-1:0]}; // R7
				end else begin
					m = 3'h2;
					dec_mmr = (req.addr >= emx_pkg::MMR_BASE); // R6
				end
				dec_sel[emx_pkg::SEL_DM] = 1'b1;
				dec_wait = wait_of(data_ext_wait_count, wait_mode); // R8
			end
			emx_pkg::SP_BM: begin
				m = 3'h1;
				dec_sel[emx_pkg::SEL_BM] = 1'b1;
				dec_wait = byte_wait_count;
			end
			emx_pkg::SP_IO: begin
				// Only the I/O request kind reaches this space
				m = 3'h1; // R10
				dec_addr = {{(emx_pkg::ADDR_W-emx_pkg::IO_ADDR_W){1'b0}},
					req.addr[emx_pkg::IO_ADDR_W-1:0]}; // R9
				dec_sel[emx_pkg::SEL_IO] = 1'b1;
				dec_wait = wait_of(io_field, wait_mode); // R11 R12
			end
		endcase
		dec_ext = m[0];
		dec_int = m[1];
		dec_err = m[2];
		// Host mode cannot fetch code over the narrow external bus
		if (q.host && req.fetch && dec_ext) begin
			dec_ext = 1'b0; // R5
			dec_err = 1'b1; // R5
		end
		// Host mode drives only the lowest address line
		if (q.host) begin
			dec_addr = {{(emx_pkg::ADDR_W-1){1'b0}}, dec_addr[0]}; // R4 R13
		end
		if (!dec_ext) begin
			dec_sel = '0; // R22
		end
	end

	// Access sequencer
	always_comb begin
		d = q;
		d.rsp = '0;
		// Strap is followed all through reset and held after release
		d.host = nrst ? q.host : flag_pin_two; // R20
		if (cse_wr) begin
			d.cse = cse_wdata;
		end
		unique case (q.state)
			emx_pkg::ST_IDLE: begin
				if (bus_request) begin
					d.state = emx_pkg::ST_GRANT;
				end else if (req.valid) begin
					if (dec_ext) begin
						d.state = emx_pkg::ST_STROBE;
						d.addr = dec_addr;
						d.sel = dec_sel;
						d.cnt = dec_wait; // R21
						d.rd = !req.write;
						d.wr = req.write;
					end else begin
						// Internal hits and refused accesses finish next cycle
						d.state = emx_pkg::ST_DONE; // R8
						d.rsp.err = dec_err; // R5 R22
						d.rsp.internal_hit = dec_int; // R2
						d.rsp.mmr_hit = dec_mmr; // R6
						d.rsp.done = 1'b1;
					end
				end
			end
			emx_pkg::ST_STROBE: begin
				if (q.cnt == '0) begin
					d.state = emx_pkg::ST_DONE;
					d.sel = '0;
					d.rd = 1'b0;
					d.wr = 1'b0;
					d.rsp.done = 1'b1;
				end else begin
					d.cnt = q.cnt - 1'b1; // R21
				end
			end
			emx_pkg::ST_DONE: begin
				d.state = emx_pkg::ST_IDLE;
			end
			emx_pkg::ST_GRANT: begin
				if (!bus_request) begin
					d.state = emx_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// Selects and composite are released while the bus is granted
	assign release_next = (d.state == emx_pkg::ST_GRANT); // R16

	// State register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			q <= CTRL_RESET; // R17 R19
			q.host <= d.host; // R20
		end else begin
			q <= d;
		end
	end

	// Strobe pins with their composite copy
	emx_sel_stage #(
		.N(emx_pkg::NUM_SEL)
	) u_sel (
		.clk(clk),
		.nrst(nrst),
		.sel_next(d.sel),
		.enables(d.cse),
		.release_next(release_next),
		.sel_n({io_space_select_n, byte_space_select_n,
			data_space_select_n, program_space_select_n}),
		.composite_n(composite_chip_select_n),
		.oe_n(select_oe_n)
	);

	// Output drive
	assign host_mode = q.host;
	assign composite_select_enables = q.cse;
	assign req_ready = (q.state == emx_pkg::ST_IDLE) && !bus_request;
	assign rsp = q.rsp;
	assign bus_grant = (q.state == emx_pkg::ST_GRANT);
	assign ext_addr = q.addr;
	assign ext_rd_n = !q.rd;
	assign ext_wr_n = !q.wr;

endmodule

// *** bench/emx_mem_ctrl_props.sv ***
`timescale 1ns/100ps
// Pin-level checks of the memory controller
module emx_mem_ctrl_props (
	input logic clk, nrst, host_mode, wait_mode, bus_request, bus_grant, req_ready,
	input logic program_space_select_n, data_space_select_n, byte_space_select_n,
	input logic io_space_select_n, composite_chip_select_n, select_oe_n,
	input logic [3:0] program_overlay_select, data_overlay_select, composite_select_enables,
	input logic [2:0] data_ext_wait_count,
	input logic [11:0] io_region_wait_counts,
	input logic [13:0] ext_addr,
	input emx_pkg::emx_req_t req,
	input emx_pkg::emx_rsp_t rsp
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [3:0] s;
	logic [4:0] cnt_q;
	logic [1:0] rg_q;
	// Expected strobe length from a wait field and the mode bit
	function automatic logic [4:0] w(logic [2:0] f, logic m);
		return (m ? {1'h0, f, 1'h1} : {2'h0, f}) + 5'h1;
	endfunction
	// Active selects, strobe length so far, I/O region of the strobe
	assign s = ~{io_space_select_n, byte_space_select_n, data_space_select_n,
		program_space_select_n};
	always_ff @(posedge clk) begin
		cnt_q <= (!nrst || s == 4'h0) ? 5'h0 : cnt_q + 5'h1;
		rg_q <= ext_addr[10:9];
	end
	property p_cms; composite_chip_select_n == !(|(s & composite_select_enables)); endproperty
	a_cms: assert property (p_cms) else $error("composite select wrong");
	property p_grant; bus_grant |-> composite_chip_select_n && s == 4'h0 && select_oe_n; endproperty
	a_grant: assert property (p_grant) else $error("select driven in grant");
	property p_ready; bus_request |-> !req_ready; endproperty
	a_ready: assert property (p_ready) else $error("ready under request");
	property p_int; req.valid && req_ready && req.space == emx_pkg::SP_DM && req.addr[13]
		|=> rsp.done && rsp.internal_hit && s == 4'h0; endproperty
	a_int: assert property (p_int) else $error("internal access not single cycle");
	property p_dlen; $rose(data_space_select_n) |-> cnt_q == w(data_ext_wait_count, wait_mode);
	endproperty
	a_dlen: assert property (p_dlen) else $error("data strobe length");
	property p_iolen; $rose(io_space_select_n)
		|-> cnt_q == w(io_region_wait_counts[3*rg_q +: 3], wait_mode); endproperty
	a_iolen: assert property (p_iolen) else $error("io strobe length");
	property p_da13; s[1] && !host_mode |-> ext_addr[13] == data_overlay_select[1]; endproperty
	a_da13: assert property (p_da13) else $error("data window bit");
	property p_pa13; s[0] && !host_mode |-> ext_addr[13] == program_overlay_select[1];
	endproperty
	a_pa13: assert property (p_pa13) else $error("program window bit");
	property p_io; s[3] |-> ext_addr[13:11] == 3'h0; endproperty
	a_io: assert property (p_io) else $error("io upper bits");
	property p_host; host_mode && s != 4'h0 |-> ext_addr[13:1] == 13'h0; endproperty
	a_host: assert property (p_host) else $error("host address");
	property p_rst; $rose(nrst) |-> composite_select_enables == 4'hB; endproperty
	a_rst: assert property (p_rst) else $error("enable reset value");
	c_io: cover property ($rose(io_space_select_n));
	c_grant: cover property (bus_grant);
	c_err: cover property (rsp.done && rsp.err);
endmodule
bind emx_mem_ctrl emx_mem_ctrl_props chk (.*);

// *** bench/emx_mem_model.sv ***
`timescale 1ns/100ps
// Far-side memory: records each select strobe seen on the pins
module emx_mem_model (
	input logic clk,
	input logic [3:0] sel_n,
	input logic cms_n,
	input logic [13:0] addr,
	output logic [4:0] len_q,
	output logic [13:0] a_q,
	output logic [3:0] hit_q,
	output logic cm_q,
	output int nacc
);
	logic [4:0] cnt_q = 5'h0;
	initial nacc = 0;
	// Address and selects at strobe start, length at its end
	always @(posedge clk) begin
		if (sel_n != 4'hF) begin
			if (cnt_q == 5'h0) begin
				a_q <= addr;
				hit_q <= ~sel_n;
				cm_q <= !cms_n;
				nacc <= nacc + 1;
			end
			cnt_q <= cnt_q + 5'h1;
		end else if (cnt_q != 5'h0) begin
			len_q <= cnt_q;
			cnt_q <= 5'h0;
		end
	end
endmodule

// *** bench/emx_mem_ctrl_bench.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module emx_mem_ctrl_bench;
	typedef struct packed {logic [1:0] sp; logic [3:0] ov; logic [13:0] a, ea;} emx_row_t;
	logic clk = 1'h0, nrst = 1'h0, strap = 1'h0, wm = 1'h0, cse_wr = 1'h0, br = 1'h0;
	logic [3:0] povl = 4'h0, dovl = 4'h0, cse_wd = 4'h0, bw = 4'h5, en, mhit;
	logic [2:0] dw = 3'h3;
	logic [11:0] iow = 12'hE11;
	logic [13:0] ea, maddr;
	logic [4:0] len;
	logic rdy, hm, gnt, oe_n, rd_n, wr_n, pm_n, dm_n, bm_n, io_n, cms_n, mcms;
	emx_pkg::emx_req_t req = '0;
	emx_pkg::emx_rsp_t rsp, rs;
	int err_total = 0, check_count = 0, nacc, n0;
	emx_row_t rows [9] = '{'{2'h1, 4'h1, 14'h1234, 14'h1234}, '{2'h1, 4'h2, 14'h0FFF, 14'h2FFF},
		'{2'h0, 4'h1, 14'h2ABC, 14'h0ABC}, '{2'h0, 4'h2, 14'h3FFF, 14'h3FFF},
		'{2'h3, 4'h0, 14'h01FF, 14'h01FF}, '{2'h3, 4'h0, 14'h3A00, 14'h0200},
		'{2'h3, 4'h0, 14'h05FF, 14'h05FF}, '{2'h3, 4'h0, 14'h0600, 14'h0600},
		'{2'h2, 4'h0, 14'h1555, 14'h1555}};
	always #4 clk = ~clk;
	emx_mem_ctrl uut (.clk(clk), .nrst(nrst), .flag_pin_two(strap), .host_mode(hm),
		.program_overlay_select(povl), .data_overlay_select(dovl), .data_ext_wait_count(dw),
		.byte_wait_count(bw), .io_region_wait_counts(iow), .wait_mode(wm), .cse_wr(cse_wr),
		.cse_wdata(cse_wd), .composite_select_enables(en), .req(req), .req_ready(rdy),
		.rsp(rsp), .bus_request(br), .bus_grant(gnt), .ext_addr(ea), .ext_rd_n(rd_n),
		.ext_wr_n(wr_n), .program_space_select_n(pm_n), .data_space_select_n(dm_n),
		.byte_space_select_n(bm_n), .io_space_select_n(io_n),
		.composite_chip_select_n(cms_n), .select_oe_n(oe_n));
	emx_mem_model mem (.clk(clk), .sel_n({io_n, bm_n, dm_n, pm_n}), .cms_n(cms_n),
		.addr(ea), .len_q(len), .a_q(maddr), .hit_q(mhit), .cm_q(mcms), .nacc(nacc));
	// Strobe cycles expected for an access
	function automatic logic [4:0] lenx(logic [1:0] sp, logic [13:0] a);
		logic [2:0] f;
		f = sp == 2'h3 ? iow[3*a[10:9] +: 3] : dw;
		if (sp == 2'h0) return 5'h1;
		if (sp == 2'h2) return {1'h0, bw} + 5'h1;
		return (wm ? {1'h0, f, 1'h1} : {2'h0, f}) + 5'h1;
	endfunction
	task automatic rst(input logic s);
		@(posedge clk);
		nrst <= 1'h0;
		strap <= s;
		repeat (4) @(posedge clk);
		nrst <= 1'h1;
		@(negedge clk);
	endtask
	// One access; returns one cycle after the cycle that carries done
	task automatic acc(input logic [1:0] sp, input logic [13:0] a, input logic f,
		input logic [3:0] ov);
		@(posedge clk);
		povl <= ov;
		dovl <= ov;
		req <= '{1'h1, emx_pkg::emx_space_t'(sp), 1'h0, f, a};
		repeat (20) begin @(negedge clk); if (rdy === 1'h1) break; end
		@(posedge clk);
		req.valid <= 1'h0;
		repeat (40) begin @(negedge clk); if (rsp.done === 1'h1) break; end
		// Keep the response; the model reports the strobe length one edge later
		rs = rsp;
		@(negedge clk);
	endtask
	task automatic close_out;
		$display("mismatches %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin #100000; err_total++; close_out; end
	initial begin
		rst(1'h0);
		`CHK(en, 4'hB)
		`CHK(hm, 1'h0)
		`CHK({oe_n, cms_n, pm_n, dm_n, bm_n, io_n}, 6'h1F)
		for (int m = 0; m < 2; m++) begin
			@(posedge clk) wm <= m[0];
			foreach (rows[i]) begin
				acc(rows[i].sp, rows[i].a, 1'h0, rows[i].ov);
				`CHK(rs.err, 1'h0)
				`CHK(len, lenx(rows[i].sp, rows[i].a))
				`CHK(maddr, rows[i].ea)
				`CHK(mhit, 4'h1 << rows[i].sp)
				`CHK(mcms, 4'hB >> rows[i].sp & 4'h1)
			end
		end
		n0 = nacc;
		acc(2'h1, 14'h3FE5, 1'h0, 4'h0);
		`CHK({rs.internal_hit, rs.mmr_hit}, 2'h3)
		acc(2'h1, 14'h0010, 1'h0, 4'h3);
		`CHK(rs.err, 1'h1)
		`CHK(nacc, n0)
		@(posedge clk) begin cse_wr <= 1'h1; cse_wd <= 4'h6; end
		@(posedge clk) cse_wr <= 1'h0;
		acc(2'h0, 14'h2001, 1'h0, 4'h1);
		`CHK(mcms, 1'h0)
		acc(2'h2, 14'h0001, 1'h0, 4'h0);
		`CHK({en, mcms}, 5'hD)
		@(posedge clk) br <= 1'h1;
		repeat (3) @(negedge clk);
		`CHK({gnt, oe_n, cms_n, rdy}, 4'hE)
		@(posedge clk) br <= 1'h0;
		repeat (3) @(negedge clk);
		`CHK(gnt, 1'h0)
		rst(1'h1);
		`CHK(hm, 1'h1)
		acc(2'h1, 14'h1235, 1'h0, 4'h1);
		`CHK(maddr, 14'h0001)
		acc(2'h0, 14'h2000, 1'h1, 4'h1);
		`CHK(rs.err, 1'h1)
		close_out;
	end
endmodule
